// ---- scmc_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of the mode-control block
`ifndef SCMC_CFG_SVH
`define SCMC_CFG_SVH
`define SCMC_OFF_MODE0     4'h0
`define SCMC_OFF_MODE1     4'h1
`define SCMC_OFF_MODE2     4'h2
`define SCMC_OFF_CTRL      4'h3
`define SCMC_OFF_BUF       4'h4
`define SCMC_M0_RXE        5
`define SCMC_M0_TB8        7
`define SCMC_M1_IDLE       7
`define SCMC_M1_DPX_HI     6
`define SCMC_M1_DPX_LO     5
`define SCMC_M1_TXE        4
`define SCMC_M1_GAP_HI     3
`define SCMC_M1_GAP_LO     1
`define SCMC_M2_TBEMP      7
`define SCMC_M2_RX_BUFFER_FULL      6
`define SCMC_M2_TXRUN      5
`define SCMC_M2_STOP_BIT_LENGTH      4
`define SCMC_M2_ORDER      3
`define SCMC_M2_DOUBLE_BUFFER_ENABLE       2
`define SCMC_CR_OVERRUN_ERROR       4
`define SCMC_CR_PARITY_UNDERRUN_ERROR       3
`define SCMC_CR_FRAMING_ERROR       2
`define SCMC_CR_IOC        0
`define SCMC_M2_RESET      8'h80
`define SCMC_SRST_FIRST    2'h1
`define SCMC_SRST_SECOND   2'h2
`define SCMC_SRST_DELAY    2'h2
`define SCMC_STOP_TWO      4'h2
`define SCMC_STOP_ONE      4'h1
`endif

// ---- scmc_mode_control.sv ----
// Mode control, buffering and software reset of one serial channel
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "scmc_cfg.svh"
module scmc_mode_control #(
  parameter int GAP_MAX = 64
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        idleMode,
  input  wire logic        bitTick,
  input  wire logic        serialClockPin,
  input  wire logic        rxData,
  input  wire logic        rxStop,
  input  wire logic        rxDone,
  input  wire logic        rxOverrun,
  input  wire logic        rxParity,
  input  wire logic        rxFraming,
  output logic             txLine,
  output logic             txActive
);
  // Registers
  logic [7:0] modeRegZero;
  logic [7:0] modeRegOne;
  logic [5:0] modeCfgTwo;
  logic [7:0] channelControlReg;
  logic       txBufferEmpty;
  logic       rxBufferFull;
  logic       txRunning;
  logic [7:0] txHold;
  logic [7:0] rxHold;
  logic [8:0] rxShift;
  logic [8:0] txShift;
  logic [3:0] txBits;
  logic [3:0] stopLeft;
  logic [6:0] gapLeft;
  logic       txPending;
  logic [1:0] srstArm;
  logic [1:0] srstWait;
  logic       srstGo;
  logic [2:0] pinSync;
  logic       pinLevel;
  logic       pinRise;
  scmc_pkg::scmc_tx_t txState;

  // Decoded controls
  scmc_pkg::scmc_mode_t mode;
  scmc_pkg::scmc_dpx_t  dpx;
  logic isIo;
  logic runEn;
  logic txAllowed;
  logic extClk;
  logic stepTick;
  logic wrAcc;
  logic rdAcc;
  assign mode   = scmc_pkg::scmc_mode_t'(modeRegZero[3:2]);
  assign dpx    = scmc_pkg::scmc_dpx_t'(modeRegOne[`SCMC_M1_DPX_HI:`SCMC_M1_DPX_LO]);
  assign isIo   = (mode == scmc_pkg::SCMC_IO);
  assign extClk = isIo && channelControlReg[`SCMC_CR_IOC];
  assign runEn  = !idleMode || modeRegOne[`SCMC_M1_IDLE];
  // UART ignores duplex for direction; clocked mode needs TX or full
  assign txAllowed = modeRegOne[`SCMC_M1_TXE] && runEn
                   && (!isIo || dpx == scmc_pkg::SCMC_DPX_TX
                       || dpx == scmc_pkg::SCMC_DPX_FULL);
  assign stepTick = runEn && (extClk ? pinRise : bitTick);
  assign wrAcc = avs_write && !avs_waitrequest;
  assign rdAcc = avs_read && !avs_waitrequest;

  // Gap length in serial clocks for a code
  function automatic logic [6:0] gapLen(input logic [2:0] code);
    gapLen = (code == 3'h0) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
  endfunction

  // Bit-order aware next bit of a frame
  function automatic logic pickBit(input logic [8:0] sh, input logic msb,
                                   input logic [3:0] n);
    pickBit = msb ? sh[n - 4'h1] : sh[0];
  endfunction

  // Serial clock pin: three stages, edge when stage two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinSync <= 3'h0;
    end else begin
      pinSync <= {pinSync[1:0], serialClockPin};
    end
  end

  // Filtered pin level and its rising edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinLevel <= 1'b0;
      pinRise  <= 1'b0;
    end else begin
      pinRise <= 1'b0;
      if (pinSync[2] == pinSync[1] && pinSync[1] != pinLevel) begin
        pinLevel <= pinSync[1];
        pinRise  <= pinSync[1];
      end
    end
  end

  // Bus slave: one wait cycle per access so answers come from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // Read data mux; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        `SCMC_OFF_MODE0: avs_readdata <= {24'h0, modeRegZero};
        `SCMC_OFF_MODE1: avs_readdata <= {24'h0, modeRegOne};
        `SCMC_OFF_MODE2: avs_readdata <= {24'h0, txBufferEmpty, rxBufferFull, txRunning,
                                          modeCfgTwo[`SCMC_M2_STOP_BIT_LENGTH:`SCMC_M2_DOUBLE_BUFFER_ENABLE],
                                          2'h0};
        `SCMC_OFF_CTRL:  avs_readdata <= {24'h0, channelControlReg};
        `SCMC_OFF_BUF:   avs_readdata <= {24'h0, rxHold};
        default:         avs_readdata <= 32'h0;
      endcase
    end
  end

  // Soft reset: 01 then 10 arms a two-clock delay
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      srstArm  <= 2'h0;
      srstWait <= 2'h0;
      srstGo   <= 1'b0;
    end else begin
      srstGo <= 1'b0;
      if (srstWait != 2'h0) begin
        srstWait <= srstWait - 2'h1;
        srstGo   <= (srstWait == 2'h1);
      end
      if (wrAcc && avs_address == `SCMC_OFF_MODE2) begin
        srstArm <= avs_writedata[1:0];
        if (srstArm == `SCMC_SRST_FIRST && avs_writedata[1:0] == `SCMC_SRST_SECOND) begin
          srstWait <= `SCMC_SRST_DELAY;
        end
      end
    end
  end

  // Mode registers; soft reset drops both enables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      modeRegZero <= 8'h00;
      modeRegOne  <= 8'h00;
      modeCfgTwo  <= 6'h00;
    end else begin
      if (wrAcc && avs_address == `SCMC_OFF_MODE0) modeRegZero <= avs_writedata[7:0];
      if (wrAcc && avs_address == `SCMC_OFF_MODE1) modeRegOne <= {avs_writedata[7:1], 1'b0};
      if (wrAcc && avs_address == `SCMC_OFF_MODE2) modeCfgTwo <= avs_writedata[5:0];
      if (srstGo) begin
        modeRegZero[`SCMC_M0_RXE] <= 1'b0;
        modeRegOne[`SCMC_M1_TXE]  <= 1'b0;
      end
    end
  end

  // Control register; error flags set-wins over read clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channelControlReg <= 8'h00;
    end else begin
      if (wrAcc && avs_address == `SCMC_OFF_CTRL) begin
        channelControlReg[7:5] <= avs_writedata[7:5];
        channelControlReg[1:0] <= avs_writedata[1:0];
      end
      if (rdAcc && avs_address == `SCMC_OFF_CTRL) channelControlReg[4:2] <= 3'h0;
      if (srstGo) channelControlReg[4:2] <= 3'h0;
      if (rxDone && runEn && modeRegZero[`SCMC_M0_RXE]) begin
        if (rxOverrun) channelControlReg[`SCMC_CR_OVERRUN_ERROR] <= 1'b1;
        if (rxParity)  channelControlReg[`SCMC_CR_PARITY_UNDERRUN_ERROR] <= 1'b1;
        if (rxFraming || !rxStop) channelControlReg[`SCMC_CR_FRAMING_ERROR] <= 1'b1;
      end
    end
  end

  // Receive shift register gathers bits; order per mode
  always_ff @(posedge clk) begin
    if (sys_rst || srstGo) begin
      rxShift <= 9'h000;
    end else if (stepTick && modeRegZero[`SCMC_M0_RXE]) begin
      rxShift <= (isIo && modeCfgTwo[3]) ? {rxShift[7:0], rxData}
                                           : {rxData, rxShift[8:1]};
    end
  end

  // Receive double buffer: always used for UART and external clock
  always_ff @(posedge clk) begin
    if (sys_rst || srstGo) begin
      rxHold       <= 8'h00;
      rxBufferFull <= 1'b0;
    end else begin
      if (rdAcc && avs_address == `SCMC_OFF_MODE2) rxBufferFull <= 1'b0;
      if (rxDone && runEn && modeRegZero[`SCMC_M0_RXE]) begin
        rxHold <= rxShift[7:0];
        if (modeCfgTwo[2] || !isIo || extClk) rxBufferFull <= 1'b1;
      end
    end
  end

  // Transmit holding register and empty flag; write clears, move sets only with double buffering enabled
  always_ff @(posedge clk) begin
    if (sys_rst || srstGo) begin
      txHold        <= 8'h00;
      txPending     <= 1'b0;
      txBufferEmpty <= 1'b1;
    end else begin
      if (txState == scmc_pkg::SCMC_TX_IDLE && txPending && txAllowed) begin
        txPending     <= 1'b0;
        txBufferEmpty <= modeCfgTwo[2];
      end
      if (wrAcc && avs_address == `SCMC_OFF_BUF) begin
        txHold        <= avs_writedata[7:0];
        txPending     <= 1'b1;
        txBufferEmpty <= 1'b0;
      end
    end
  end

  // Transmit engine; clearing enable lets the frame finish
  always_ff @(posedge clk) begin
    if (sys_rst || srstGo) begin
      txState   <= scmc_pkg::SCMC_TX_IDLE;
      txShift   <= 9'h1FF;
      txBits    <= 4'h0;
      stopLeft  <= 4'h0;
      gapLeft   <= 7'h00;
      txRunning <= 1'b0;
      txLine    <= 1'b1;
      txActive  <= 1'b0;
    end else begin
      unique case (txState)
        scmc_pkg::SCMC_TX_IDLE: begin
          txLine <= 1'b1;
          if (txPending && txAllowed) begin
            txState   <= scmc_pkg::SCMC_TX_SHIFT;
            txRunning <= 1'b1;
            txActive  <= 1'b1;
            unique case (mode)
              scmc_pkg::SCMC_IO:    begin txShift <= {1'b1, txHold}; txBits <= 4'h8; end
              scmc_pkg::SCMC_UART7: begin txShift <= {txHold, 1'b0}; txBits <= 4'h8; end
              scmc_pkg::SCMC_UART8: begin txShift <= {txHold, 1'b0}; txBits <= 4'h9; end
              scmc_pkg::SCMC_UART9: begin txShift <= {txHold, 1'b0}; txBits <= 4'hA; end
            endcase
          end
        end
        scmc_pkg::SCMC_TX_SHIFT: if (stepTick) begin
          txLine <= pickBit(txShift, isIo && modeCfgTwo[3], txBits);
          // Ninth data bit enters behind the start bit, so it leaves last
          txShift <= (isIo && modeCfgTwo[`SCMC_M2_ORDER]) ? txShift
                   : {(txBits == 4'hA) ? modeRegZero[`SCMC_M0_TB8] : 1'b1,
                      txShift[8:1]};
          txBits  <= txBits - 4'h1;
          if (txBits == 4'h1) begin
            stopLeft <= isIo ? 4'h0
                      : (modeCfgTwo[4] ? `SCMC_STOP_TWO : `SCMC_STOP_ONE);
            txState  <= isIo ? scmc_pkg::SCMC_TX_GAP : scmc_pkg::SCMC_TX_STOP;
            gapLeft  <= (isIo && !extClk && (modeCfgTwo[2] || txPending))
                      ? gapLen(modeRegOne[`SCMC_M1_GAP_HI:`SCMC_M1_GAP_LO]) : 7'h00;
          end
        end
        scmc_pkg::SCMC_TX_STOP: if (stepTick) begin
          txLine   <= 1'b1;
          stopLeft <= stopLeft - 4'h1;
          if (stopLeft == 4'h1) txState <= scmc_pkg::SCMC_TX_GAP;
        end
        scmc_pkg::SCMC_TX_GAP: begin
          if (gapLeft == 7'h00) begin
            txState   <= scmc_pkg::SCMC_TX_IDLE;
            txRunning <= 1'b0;
            txActive  <= 1'b0;
          end else if (stepTick) begin
            gapLeft <= gapLeft - 7'h01;
          end
        end
        default: txState <= scmc_pkg::SCMC_TX_IDLE;
      endcase
    end
  end

  // Soft reset follows the second write by exactly three edges
  sequence seqSrstWrite;
    wrAcc && avs_address == `SCMC_OFF_MODE2 && srstArm == `SCMC_SRST_FIRST
      && avs_writedata[1:0] == `SCMC_SRST_SECOND;
  endsequence
  chk_srst_delay_fire: assert property (@(posedge clk) disable iff (sys_rst)
    seqSrstWrite |-> ##3 srstGo) else $error("soft reset not two clocks after code");
  chk_srst_clears_state: assert property (@(posedge clk) disable iff (sys_rst)
    srstGo |=> !modeRegOne[`SCMC_M1_TXE] && !modeRegZero[`SCMC_M0_RXE]
               && txBufferEmpty && !rxBufferFull && !txRunning)
    else $error("soft reset left state set");
  chk_tx_gated_enable: assert property (@(posedge clk) disable iff (sys_rst)
    txState == scmc_pkg::SCMC_TX_IDLE && !txAllowed |=> txState == scmc_pkg::SCMC_TX_IDLE)
    else $error("frame started with transmit disabled");
  chk_io_prohibit_dpx: assert property (@(posedge clk) disable iff (sys_rst)
    txState == scmc_pkg::SCMC_TX_IDLE && isIo && (dpx == scmc_pkg::SCMC_DPX_OFF
      || dpx == scmc_pkg::SCMC_DPX_RX) |=> txState == scmc_pkg::SCMC_TX_IDLE)
    else $error("clocked mode transmitted without tx duplex");
  // A frame in flight never drops straight back to idle when enable goes
  chk_frame_finishes: assert property (@(posedge clk) disable iff (sys_rst || srstGo)
    txState == scmc_pkg::SCMC_TX_SHIFT && !modeRegOne[`SCMC_M1_TXE] && !srstGo |=>
      txState != scmc_pkg::SCMC_TX_IDLE) else $error("frame cut short");
  chk_tbemp_on_write: assert property (@(posedge clk) disable iff (sys_rst)
    wrAcc && avs_address == `SCMC_OFF_BUF && !srstGo |=> !txBufferEmpty)
    else $error("buffer empty not cleared by write");
  chk_rx_buffer_full_read_clear: assert property (@(posedge clk) disable iff (sys_rst)
    rdAcc && avs_address == `SCMC_OFF_MODE2 && !rxDone |=> !rxBufferFull)
    else $error("buffer full not cleared by read");
  chk_run_flag_match: assert property (@(posedge clk) disable iff (sys_rst)
    txRunning == (txState != scmc_pkg::SCMC_TX_IDLE)) else $error("running flag wrong");
  chk_uart_rx_buffered: assert property (@(posedge clk) disable iff (sys_rst)
    rxDone && runEn && modeRegZero[`SCMC_M0_RXE] && !isIo && !srstGo |=> rxBufferFull)
    else $error("uart receive not buffered");
  chk_gap_ext_none: assert property (@(posedge clk) disable iff (sys_rst)
    txState == scmc_pkg::SCMC_TX_SHIFT && stepTick && txBits == 4'h1 && (extClk || !isIo)
      |=> gapLeft == 7'h00) else $error("gap used outside clocked internal mode");
  chk_idle_stop: assert property (@(posedge clk) disable iff (sys_rst)
    idleMode && !modeRegOne[`SCMC_M1_IDLE] |-> !stepTick) else $error("ran in idle");

  // Last data step of a UART frame, where the stop phase is loaded
  sequence seqUartLastStep;
    txState == scmc_pkg::SCMC_TX_SHIFT && stepTick && txBits == 4'h1 && !isIo;
  endsequence
  // Stop phase is one or two steps as selected
  chk_stop_length: assert property (@(posedge clk) disable iff (sys_rst || srstGo)
    seqUartLastStep |=> stopLeft == (modeCfgTwo[`SCMC_M2_STOP_BIT_LENGTH] ? 4'h2 : 4'h1))
    else $error("stop bit count wrong");
  // UART frames always leave from the low end of the shifter
  chk_uart_lsb_first: assert property (@(posedge clk) disable iff (sys_rst || srstGo)
    txState == scmc_pkg::SCMC_TX_SHIFT && stepTick && !isIo |=> txLine == $past(txShift[0]))
    else $error("uart frame not lsb first");
endmodule

// ---- scmc_partner.sv ----
// Far-side serial device: bit steps, line recorder and receive events
`timescale 1ns/1ps
module scmc_partner (
  input  wire logic clk,
  input  wire logic txLine,
  input  wire logic txActive,
  output logic      bitTick,
  output logic      serialClockPin,
  output logic      rxData,
  output logic      rxStop,
  output logic      rxDone,
  output logic      rxOverrun,
  output logic      rxParity,
  output logic      rxFraming
);
  logic [1:0]  tickDiv;
  logic [15:0] hist;
  int          nbits;
  logic        stepSeen;
  // Quiet start; external clock pin stands still, no frames on it
  initial begin
    {bitTick, serialClockPin, rxStop, rxDone, rxOverrun, rxParity, rxFraming} = 7'h00;
    rxData  = 1'b0;
    tickDiv = 2'h0;
    hist    = 16'h0000;
    nbits   = 0;
    stepSeen = 1'b0;
  end
  // Step every fourth clock; record the line one clock after a step, once settled
  always @(posedge clk) begin
    tickDiv  <= tickDiv + 2'h1;
    bitTick  <= (tickDiv == 2'h3);
    rxData   <= ~rxData; // Released line toggles, never a stale value
    stepSeen <= bitTick && txActive;
    if (stepSeen && txActive) begin
      hist  <= {hist[14:0], txLine};
      nbits <= nbits + 1;
    end
  end
  // Forget what was recorded
  task automatic clear();
    @(posedge clk);
    hist  <= 16'h0000;
    nbits <= 0;
  endtask
  // Rising edges on the clock pin, each level held long enough to pass the filter
  task automatic pin_clocks(input int n);
    repeat (n) begin
      @(posedge clk);
      serialClockPin <= 1'b1;
      repeat (4) @(posedge clk);
      serialClockPin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  // One completed reception, with its stop bit and overrun state
  task automatic send_rx(input logic stopOk, input logic ovr);
    @(posedge clk);
    rxDone    <= 1'b1;
    rxStop    <= stopOk;
    rxOverrun <= ovr;
    @(posedge clk);
    rxDone    <= 1'b0;
    rxStop    <= ~stopOk;
    rxOverrun <= 1'b0;
  endtask
endmodule

// ---- scmc_pkg.sv ----
// Types shared by the mode-control block
package scmc_pkg;
  typedef enum logic [1:0] {
    SCMC_IO     = 2'h0,
    SCMC_UART7  = 2'h1,
    SCMC_UART8  = 2'h2,
    SCMC_UART9  = 2'h3
  } scmc_mode_t;
  typedef enum logic [1:0] {
    SCMC_DPX_OFF  = 2'h0,
    SCMC_DPX_RX   = 2'h1,
    SCMC_DPX_TX   = 2'h2,
    SCMC_DPX_FULL = 2'h3
  } scmc_dpx_t;
  typedef enum logic [3:0] {
    SCMC_TX_IDLE  = 4'h1,
    SCMC_TX_SHIFT = 4'h2,
    SCMC_TX_STOP  = 4'h4,
    SCMC_TX_GAP   = 4'h8
  } scmc_tx_t;
endpackage

// ---- testbench.sv ----
// Self-checking bench of the mode-control block
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        sys_rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        idleMode;
  logic        bitTick;
  logic        serialClockPin;
  logic        rxData;
  logic        rxStop;
  logic        rxDone;
  logic        rxOverrun;
  logic        rxParity;
  logic        rxFraming;
  logic        txLine;
  logic        txActive;
  int          err_count;
  int          comparisons;
  logic [31:0] q;

  scmc_mode_control i_scmc_mode_control (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .idleMode(idleMode), .bitTick(bitTick),
    .serialClockPin(serialClockPin), .rxData(rxData), .rxStop(rxStop), .rxDone(rxDone),
    .rxOverrun(rxOverrun), .rxParity(rxParity), .rxFraming(rxFraming),
    .txLine(txLine), .txActive(txActive));
  scmc_partner i_scmc_partner (.clk(clk), .txLine(txLine), .txActive(txActive),
    .bitTick(bitTick), .serialClockPin(serialClockPin), .rxData(rxData),
    .rxStop(rxStop), .rxDone(rxDone), .rxOverrun(rxOverrun), .rxParity(rxParity),
    .rxFraming(rxFraming));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Counts, verdict and end of run
  task automatic stop_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        err_count++;
        stop_test();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  // Bounded wait for the frame flag to reach a level
  task automatic wait_tx(input logic lvl);
    int n;
    n = 0;
    while (txActive !== lvl) begin
      @(posedge clk);
      n++;
      if (n > 2000) begin
        err_count++;
        stop_test();
      end
    end
  endtask
  // No frame may start in this window
  task automatic quiet();
    repeat (60) begin
      @(posedge clk);
      check("txActive", {31'h0, txActive}, 32'h0);
    end
  endtask

  task automatic t_reset();
    bus(0, 4'h2, 8'h00);
    check("mode2 reset", q, 32'h80);
    bus(0, 4'h1, 8'h00);
    check("mode1 reset", q, 32'h00);
    bus(1, 4'h7, 8'hFF);
    bus(0, 4'h7, 8'h00);
    check("unmapped", q, 32'h00);
  endtask
  // UART frame: LSB first despite order bit, one or two stop bits
  task automatic t_uart(input logic sb);
    logic [7:0]  rev;
    logic [15:0] exp;
    rev = {<<{8'h35}};
    exp = sb ? {5'h00, 1'b0, rev, 2'h3} : {6'h00, 1'b0, rev, 1'b1};
    bus(1, 4'h0, 8'h08);
    bus(1, 4'h2, {3'h0, sb, 4'hC});
    bus(1, 4'h1, 8'h10);
    i_scmc_partner.clear();
    bus(1, 4'h4, 8'h35);
    wait_tx(1);
    bus(0, 4'h2, 8'h00);
    check("running", q[5], 1);
    wait_tx(0);
    check("stop count", i_scmc_partner.nbits, 10 + sb);
    check("uart bits", i_scmc_partner.hist, exp);
    bus(0, 4'h2, 8'h00);
    check("done flags", q[7:5], 3'h4);
  endtask
  // Transmit enable and idle-run gate; a started frame completes
  task automatic t_gate();
    bus(1, 4'h1, 8'h00);
    bus(1, 4'h4, 8'h35);
    quiet();
    bus(0, 4'h2, 8'h00);
    check("waiting", q[7:5], 3'h0);
    idleMode <= 1'b1;
    bus(1, 4'h1, 8'h10);
    quiet();
    i_scmc_partner.clear();
    bus(1, 4'h1, 8'h90);
    wait_tx(1);
    repeat (12) @(posedge clk);
    bus(1, 4'h1, 8'h80);
    wait_tx(0);
    idleMode <= 1'b0;
    check("frame finished", i_scmc_partner.nbits, 11);
  endtask
  // Clocked mode: duplex gate, bit order, gap steps
  task automatic t_io();
    bus(1, 4'h0, 8'h00);
    bus(1, 4'h3, 8'h00);
    bus(1, 4'h2, 8'h0C);
    bus(1, 4'h1, 8'h10);
    bus(1, 4'h4, 8'h35);
    quiet();
    bus(1, 4'h1, 8'h30);
    quiet();
    i_scmc_partner.clear();
    bus(1, 4'h1, 8'h56);
    wait_tx(1);
    wait_tx(0);
    check("gap steps", i_scmc_partner.nbits, 12);
    check("msb first", i_scmc_partner.hist[11:4], 8'h35);
    bus(1, 4'h2, 8'h04);
    bus(1, 4'h1, 8'h50);
    i_scmc_partner.clear();
    bus(1, 4'h4, 8'h35);
    wait_tx(1);
    wait_tx(0);
    check("no gap", i_scmc_partner.nbits, 8);
    check("lsb first", i_scmc_partner.hist[7:0], 8'hAC);
  endtask
  // External clock: only pin edges step the frame, and no gap follows
  task automatic t_ext();
    bus(1, 4'h3, 8'h01);
    bus(1, 4'h1, 8'h52);
    bus(1, 4'h4, 8'hA5);
    wait_tx(1);
    repeat (60) @(posedge clk);
    check("no pin no step", {31'h0, txActive}, 32'h1);
    i_scmc_partner.pin_clocks(7);
    check("seven steps", {31'h0, txActive}, 32'h1);
    i_scmc_partner.pin_clocks(1);
    wait_tx(0);
    bus(0, 4'h2, 8'h00);
    check("ext flags", q[7:5], 3'h4);
    bus(1, 4'h3, 8'h00);
  endtask
  // Forced receive buffering, flag and error clear on read
  task automatic t_rx();
    bus(1, 4'h0, 8'h28);
    bus(1, 4'h2, 8'h00);
    i_scmc_partner.send_rx(1, 1);
    bus(0, 4'h2, 8'h00);
    check("rx full", q[6], 1);
    bus(0, 4'h2, 8'h00);
    check("rx cleared", q[6], 0);
    bus(0, 4'h3, 8'h00);
    check("overrun", q[4], 1);
    bus(0, 4'h3, 8'h00);
    check("overrun read", q[4], 0);
  endtask
  // Two-write soft reset; a broken sequence does nothing
  task automatic t_srst();
    bus(1, 4'h1, 8'h10);
    i_scmc_partner.send_rx(0, 1);
    bus(1, 4'h2, 8'h01);
    bus(1, 4'h2, 8'h00);
    bus(1, 4'h2, 8'h02);
    bus(0, 4'h1, 8'h00);
    check("no reset", q[4], 1);
    bus(1, 4'h2, 8'h01);
    bus(1, 4'h2, 8'h02);
    repeat (3) @(posedge clk);
    bus(0, 4'h0, 8'h00);
    check("rx enable", q[5], 0);
    bus(0, 4'h1, 8'h00);
    check("tx enable", q[4], 0);
    bus(0, 4'h2, 8'h00);
    check("flags", q[7:5], 3'h4);
    bus(0, 4'h3, 8'h00);
    check("errors", q[4:2], 3'h0);
    bus(1, 4'h0, 8'h08);
  endtask

  // Reset, then every scenario in turn
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = 38'h0;
    idleMode = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_uart(0);
    t_uart(1);
    t_gate();
    t_io();
    t_ext();
    t_rx();
    t_srst();
    stop_test();
  end
endmodule
